/* src/servo_sync_timing_decoder.sv */
// servo sync timing decoder: phase times, sample windows, pattern decode,
// seek-late fault, and an APB register slave with interrupt
// assumes oscillator and sync pins are asynchronous to clk
`timescale 1ns/100ps

module servo_sync_timing_decoder
  import servo_sync_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins from the servo channel
  input  wire logic        osc_clk,
  input  wire logic        sync_pin,
  // timing and status outputs
  output logic             sync_presence_pulse,
  output logic             a_window,
  output logic             b_window,
  output logic             index_flag,
  output logic             outer_zone_flag,
  output logic             seek_late,
  output logic             motor_enable,
  output logic             irq
);

  // ************************************************************
  // synchronisers and edge detection
  // ************************************************************
  logic       osc_meta, osc_sync, osc_prev;
  logic       sync_meta, sync_sync, sync_prev;
  logic       osc_rise, sync_rise;

  // two flops per pin, third flop only for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta  <= 1'b0;
      osc_sync  <= 1'b0;
      osc_prev  <= 1'b0;
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      osc_meta  <= osc_clk;
      osc_sync  <= osc_meta;
      osc_prev  <= osc_sync;
      sync_meta <= sync_pin;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  assign osc_rise  = osc_sync & ~osc_prev;
  assign sync_rise = sync_sync & ~sync_prev;

  // ************************************************************
  // phase generation
  // ************************************************************
  logic       half;
  logic [3:0] phase;
  logic       advance;

  // true in the cycle that the counter steps into phase time n
  function automatic logic at_phase(input logic adv, input logic [3:0] cur,
                                    input logic [3:0] n);
    return adv && (4'(cur + 4'h1) == n);
  endfunction

  // oscillator runs at 32x sync rate; halve, then count modulo 16
  assign advance = osc_rise & half;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half  <= 1'b0;
      phase <= 4'h0;
    end else begin
      if (osc_rise)
        half <= ~half;
      if (advance)
        phase <= 4'(phase + 4'h1);
    end
  end

  // ************************************************************
  // sync presence and pattern register
  // ************************************************************
  logic                  sync_seen;
  logic [PAT_STAGES-1:0] pattern;
  logic                  sample_now;
  logic                  freq_error;

  assign sample_now = at_phase(advance, phase, PH_SAMPLE);
  // a second sync inside one period means the loop is off frequency
  assign freq_error = sync_rise & sync_seen;

  // presence pulse: set by sync, cleared at phase ten, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sync_presence_pulse <= 1'b0;
    else if (sync_rise)
      sync_presence_pulse <= 1'b1;
    else if (at_phase(advance, phase, PH_CLEAR))
      sync_presence_pulse <= 1'b0;
  end

  // sync seen this period; shifted in even when absent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_seen <= 1'b0;
      pattern   <= '0;
    end else begin
      if (sample_now) begin
        pattern   <= {pattern[PAT_STAGES-2:0], sync_seen | sync_rise};
        sync_seen <= 1'b0;
      end else if (sync_rise) begin
        sync_seen <= 1'b1;
      end
    end
  end

  // pattern decode for index and outer zone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_flag      <= 1'b0;
      outer_zone_flag <= 1'b0;
    end else begin
      index_flag      <= (pattern[3:0] == INDEX_PAT);
      outer_zone_flag <= (pattern == OUTER_PAT_A)
                      || (pattern == OUTER_PAT_B);
    end
  end

  // ************************************************************
  // sample windows
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_window <= 1'b0;
      b_window <= 1'b0;
    end else begin
      if (at_phase(advance, phase, PH_A_OPEN))
        a_window <= 1'b1;
      else if (at_phase(advance, phase, PH_A_CLOSE))
        a_window <= 1'b0;
      if (at_phase(advance, phase, PH_B_OPEN))
        b_window <= 1'b1;
      else if (at_phase(advance, phase, PH_B_CLOSE))
        b_window <= 1'b0;
    end
  end

  // ************************************************************
  // sync loss timer and seek-late fault
  // ************************************************************
  logic [31:0] loss_cnt;
  logic        loss_expired;
  logic        fault_clear;
  logic        motor_request;

  assign loss_expired = (loss_cnt == 32'(LOSS_LIMIT - 1)) & ~sync_rise;

  // restarts on every sync edge, saturates at expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      loss_cnt <= '0;
    else if (sync_rise)
      loss_cnt <= '0;
    else if (!loss_expired)
      loss_cnt <= loss_cnt + 32'h1;
  end

  // fault is sticky; a new cause beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      seek_late <= 1'b0;
    else if (freq_error || loss_expired)
      seek_late <= 1'b1;
    else if (fault_clear)
      seek_late <= 1'b0;
  end

  // motor drive only while requested and fault free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      motor_enable <= 1'b0;
    else
      motor_enable <= motor_request & ~seek_late
                    & ~freq_error & ~loss_expired;
  end

  // ************************************************************
  // apb slave, events and interrupt
  // ************************************************************
  logic                access, wr_acc, rd_acc;
  logic [EV_WIDTH-1:0] events, mask, ev_set;
  logic                index_prev, outer_prev;
  status_type          status;

  assign access = psel & penable & pready;
  assign wr_acc = access & pwrite;
  assign rd_acc = access & ~pwrite;
  assign fault_clear = wr_acc && (paddr == OFS_CONTROL)
                       && pwdata[CTL_CLEAR_BIT];

  // one wait state: ready rises the cycle after the access phase opens
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // control and mask writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_request <= CONTROL_RESET[CTL_MOTOR_BIT];
      mask          <= MASK_RESET;
    end else if (wr_acc) begin
      if (paddr == OFS_CONTROL)
        motor_request <= pwdata[CTL_MOTOR_BIT];
      if (paddr == OFS_MASK)
        mask <= pwdata[EV_WIDTH-1:0];
    end
  end

  // event sources
  always_comb begin
    ev_set            = '0;
    ev_set[EV_INDEX]  = index_flag & ~index_prev;
    ev_set[EV_OUTER]  = outer_zone_flag & ~outer_prev;
    ev_set[EV_LATE]   = freq_error | loss_expired;
    ev_set[EV_MISSED] = sample_now & ~(sync_seen | sync_rise);
  end

  // sticky events; a read clears only the bits it returned, so an event
  // landing between the data capture and the completing edge survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      events     <= '0;
      index_prev <= 1'b0;
      outer_prev <= 1'b0;
    end else begin
      index_prev <= index_flag;
      outer_prev <= outer_zone_flag;
      if (rd_acc && paddr == OFS_EVENTS)
        events <= (events & ~prdata[EV_WIDTH-1:0]) | ev_set;
      else
        events <= events | ev_set;
    end
  end

  // level interrupt from unmasked events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(events & mask);
  end

  // live status word
  always_comb begin
    status              = '0;
    status.phase        = phase;
    status.pattern      = pattern;
    status.presence     = sync_presence_pulse;
    status.index        = index_flag;
    status.outer_zone   = outer_zone_flag;
    status.seek_late    = seek_late;
    status.motor_enable = motor_enable;
    status.a_window     = a_window;
    status.b_window     = b_window;
  end

  // read data and error answer, loaded in the wait state and held while ready is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      case (paddr)
        OFS_CONTROL: prdata <= {31'h0, motor_request};
        OFS_STATUS:  prdata <= status;
        OFS_EVENTS:  prdata <= {28'h0, events};
        OFS_MASK:    prdata <= {28'h0, mask};
        default:     pslverr <= 1'b1;
      endcase
    end else begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_phase_step;
    advance |=> phase == 4'($past(phase) + 4'h1);
  endproperty
  a_phase_step: assert property (p_phase_step)
    else $error("phase counter did not step by one");

  property p_half_rate;
    osc_rise && !half |=> phase == $past(phase);
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("phase moved on an odd oscillator edge");

  property p_presence_set;
    sync_rise |=> sync_presence_pulse;
  endproperty
  a_presence_set: assert property (p_presence_set)
    else $error("sync edge did not raise presence");

  property p_presence_clear;
    at_phase(advance, phase, PH_CLEAR) && !sync_rise
      |=> !sync_presence_pulse;
  endproperty
  a_presence_clear: assert property (p_presence_clear)
    else $error("presence not cleared at phase ten");

  property p_sample;
    sample_now |=> pattern[0] == $past(sync_seen | sync_rise)
                 && pattern[4:1] == $past(pattern[3:0]);
  endproperty
  a_sample: assert property (p_sample)
    else $error("pattern register did not shift at phase seven");

  property p_index;
    pattern[3:0] == INDEX_PAT |=> index_flag;
  endproperty
  a_index: assert property (p_index)
    else $error("index pattern not flagged");

  property p_outer;
    ##1 outer_zone_flag == ($past(pattern) == OUTER_PAT_A
                         || $past(pattern) == OUTER_PAT_B);
  endproperty
  a_outer: assert property (p_outer)
    else $error("outer zone flag disagrees with pattern");

  property p_a_window;
    at_phase(advance, phase, PH_A_OPEN) |=> a_window ##0 !b_window;
  endproperty
  a_a_window: assert property (p_a_window)
    else $error("A window not open at phase two");

  property p_b_window;
    at_phase(advance, phase, PH_B_CLOSE) |=> !b_window && !a_window;
  endproperty
  a_b_window: assert property (p_b_window)
    else $error("B window not closed at phase twelve");

  property p_late_set;
    freq_error || loss_expired |=> seek_late ##1 !motor_enable;
  endproperty
  a_late_set: assert property (p_late_set)
    else $error("fault did not set seek late and drop motor");

  property p_late_hold;
    seek_late && !fault_clear |=> seek_late;
  endproperty
  a_late_hold: assert property (p_late_hold)
    else $error("seek late dropped without clear");

  c_index: cover property (index_flag && !index_prev);
  c_outer: cover property (outer_zone_flag);
  c_loss:  cover property (loss_expired);
  c_irq:   cover property (irq ##[1:20] !irq);

endmodule

/* common/servo_sync_pkg.sv */
// constants, register map and carrier types for the servo sync timing decoder
// assumes a 40 MHz system clock and an APB master with 32-bit data
package servo_sync_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_EVENTS  = 12'h008;
  localparam logic [11:0] OFS_MASK    = 12'h00c;

  // control bit positions
  localparam int CTL_MOTOR_BIT = 0;
  localparam int CTL_CLEAR_BIT = 1;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // event bit positions
  localparam int EV_INDEX   = 0;
  localparam int EV_OUTER   = 1;
  localparam int EV_LATE    = 2;
  localparam int EV_MISSED  = 3;
  localparam int EV_WIDTH   = 4;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // phase times within one sync period
  localparam logic [3:0] PH_A_OPEN  = 4'h2;
  localparam logic [3:0] PH_A_CLOSE = 4'h6;
  localparam logic [3:0] PH_SAMPLE  = 4'h7;
  localparam logic [3:0] PH_B_OPEN  = 4'h8;
  localparam logic [3:0] PH_CLEAR   = 4'ha;
  localparam logic [3:0] PH_B_CLOSE = 4'hc;

  // pattern register decode
  localparam int          PAT_STAGES  = 5;
  localparam logic [3:0]  INDEX_PAT   = 4'h6;
  localparam logic [4:0]  OUTER_PAT_A = 5'h0a;
  localparam logic [4:0]  OUTER_PAT_B = 5'h15;

  // sync loss timer
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOSS_TIME_US  = 400;
  localparam int LOSS_CYCLES   = LOSS_TIME_US * 1000 / CLK_PERIOD_NS;

  // status register layout, high bits first
  typedef struct packed {
    logic [15:0] spare;
    logic        b_window;
    logic        a_window;
    logic        motor_enable;
    logic        seek_late;
    logic        outer_zone;
    logic        index;
    logic        presence;
    logic [4:0]  pattern;
    logic [3:0]  phase;
  } status_type;

endpackage

/* verification/servo_head_model.sv */
// model of the servo head channel: oscillator pin and sync detector output
// assumes the bench drives sync_on, skip and extra just after clk edges
`timescale 1ns/100ps

module servo_head_model (
  // control from the bench
  input  wire logic rst_n,
  input  wire logic sync_on,
  input  wire logic skip,
  input  wire logic extra,
  // pins towards the decoder, and frame_start for the bench
  output logic      osc_clk,
  output logic      sync_pin,
  output logic      frame_start
);
  logic [4:0] cnt;
  logic       skip_q;
  logic       extra_q;

  // oscillator still in reset, then 200 ns free run at an odd phase
  initial begin
    osc_clk = 1'b0;
    wait (rst_n === 1'b1);
    #7;
    forever #100 osc_clk = ~osc_clk;
  end

  // 32 oscillator cycles per sync period; choices land at period start
  always @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 5'h00;
      skip_q  <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h1f) begin
        skip_q  <= skip;
        extra_q <= extra;
      end
    end
  end

  // one sync slot per period shared by both tracks; extra pulse on request
  assign sync_pin = sync_on & ((cnt < 5'h02 & ~skip_q) |
                    (extra_q & (cnt[4:1] == 4'h4)));
  assign frame_start = (cnt == 5'h00);
endmodule

/* verification/tb_servo_sync_timing_decoder.sv */
// self-checking bench for the servo sync timing decoder
// assumes the head model in servo_head_model.sv and an APB master here
`timescale 1ns/100ps

module tb_servo_sync_timing_decoder;
  import servo_sync_pkg::*;
  localparam int          LOSS = 600;
  localparam logic [32:0] ALL  = 33'h1_ffff_ffff;
  localparam logic [32:0] ERRB = 33'h1_0000_0000;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        osc_clk, sync_pin, sync_presence_pulse, a_window, b_window;
  logic        index_flag, outer_zone_flag, seek_late, motor_enable, irq;
  logic        sync_on, skip, extra, frame_start;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [3:0]  rmask;
  int          n_fail, n_checks, hi;

  servo_sync_timing_decoder #(.LOSS_LIMIT(LOSS)) i_dut (.clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .osc_clk, .sync_pin, .sync_presence_pulse, .a_window, .b_window,
    .index_flag, .outer_zone_flag, .seek_late, .motor_enable, .irq);
  servo_head_model i_head (.rst_n, .sync_on, .skip, .extra, .osc_clk,
    .sync_pin, .frame_start);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************
  // helper tasks
  // ****************
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, ERRB);
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge frame_start);
      @(posedge clk);
    end
  endtask

  // one present period, then one period per bit, oldest first
  task automatic pat(input logic [7:0] p, input int n);
    frames(1);
    for (int i = n - 1; i >= 0; i--) begin
      skip <= p[i];
      frames(1);
    end
    skip <= 1'b0;
  endtask

  // run past the phase seven sample, counting presence high cycles
  task automatic settle();
    hi = 0;
    repeat (140) begin
      @(posedge clk);
      if (sync_presence_pulse === 1'b1) hi++;
    end
  endtask

  // window and presence widths over one period; a phase is 16 clks
  task automatic windows();
    int ta, tb, na, nb, np;
    na = 0;
    nb = 0;
    np = 0;
    frames(1);
    for (int t = 0; t < 256; t++) begin
      @(posedge clk);
      if (a_window === 1'b1 && na++ == 0) ta = t;
      if (b_window === 1'b1 && nb++ == 0) tb = t;
      if (sync_presence_pulse === 1'b1) np++;
    end
    check(na, (PH_A_CLOSE - PH_A_OPEN) * 16);
    check(nb, (PH_B_CLOSE - PH_B_OPEN) * 16);
    check(tb - ta, (PH_B_OPEN - PH_A_OPEN) * 16);
    check(np > 150 && np <= 170, 1);
  endtask

  // ****************
  // monitor and watchdog
  // ****************
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("ERROR %0t: ready with no transfer pending", $time);
      end else begin
        check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  // the run needs about 10000 clks
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sync_on = 1'b1;
    skip = 1'b0;
    extra = 1'b0;
    n_fail = 0;
    n_checks = 0;
    rmask = 4'($urandom(55611));
    repeat (20) @(posedge clk);
    check({seek_late, motor_enable, irq, a_window}, 33'h0);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, {1'b0, CONTROL_RESET}, ALL);
    rd(OFS_MASK, {29'h0, MASK_RESET}, ALL);
    rd(OFS_EVENTS, 33'h0, ALL);
    rd(12'h010, ERRB, ALL);
    wr(OFS_MASK, {28'h0, rmask});
    rd(OFS_MASK, {29'h0, rmask}, ALL);
    wr(OFS_CONTROL, 32'h3);
    rd(OFS_CONTROL, 33'h1, ALL);
    // missed sync raises a masked-in interrupt, read clears it
    wr(OFS_MASK, 32'h8);
    rd(OFS_EVENTS, 33'h0, 33'h0);
    pat(8'h01, 1);
    settle();
    check(irq, 1);
    check(hi, 0);
    rd(OFS_EVENTS, 33'h8, 33'h1_0000_0008);
    repeat (3) @(posedge clk);
    check(irq, 0);
    wr(OFS_MASK, 32'h0);
    pat(8'h01, 1);
    settle();
    check(irq, 0);
    // marker: missing, two present, missing
    rd(OFS_EVENTS, 33'h0, 33'h0);
    pat(8'b1001, 4);
    settle();
    check(index_flag, 1);
    check(hi, 0);
    rd(OFS_STATUS, 33'h560, 33'h1_0000_07f0);
    frames(2);
    rd(OFS_EVENTS, 33'h9, 33'h1_0000_0009);
    // alternate dropped syncs
    rd(OFS_EVENTS, 33'h0, 33'h0);
    pat(8'b10101, 5);
    settle();
    check(outer_zone_flag, 1);
    check(hi, 0);
    frames(3);
    check(outer_zone_flag, 0);
    rd(OFS_EVENTS, 33'h2, 33'h1_0000_0002);
    windows();
    // two syncs in one period
    check({seek_late, motor_enable}, 33'h1);
    frames(1);
    extra <= 1'b1;
    frames(1);
    extra <= 1'b0;
    frames(1);
    repeat (4) @(posedge clk);
    check({seek_late, motor_enable}, 33'h2);
    rd(OFS_EVENTS, 33'h4, 33'h1_0000_0004);
    frames(2);
    check(seek_late, 1);
    wr(OFS_CONTROL, 32'h3);
    repeat (3) @(posedge clk);
    check({seek_late, motor_enable}, 33'h1);
    // sustained sync loss
    sync_on <= 1'b0;
    repeat (LOSS + 300) @(posedge clk);
    check({seek_late, motor_enable}, 33'h2);
    sync_on <= 1'b1;
    frames(2);
    wr(OFS_CONTROL, 32'h3);
    repeat (3) @(posedge clk);
    check(seek_late, 0);
    rd(OFS_STATUS, 33'h2000, 33'h1_0000_3000);
    summarize();
  end
endmodule
